// ===== logic/nrzi_multitrack_codec_deskew.sv
// Purpose: Multitrack NRZI write encoder with write deskew, and read decoder
//          with a capture window that removes inter-track skew.
// Assumes: All inputs are synchronous to CLK; read pulses are one cycle.
// Notes:   The top track is the parity track and the write reference.
`timescale 1ns/10ps
`default_nettype none
`include "nrzi_codec_defines.svh"

module nrzi_multitrack_codec_deskew #(
   parameter int TRACKS = 9
) (
   // Clock and reset.
   input  wire logic                      CLK,
   input  wire logic                      RST,
   // Mode selection.
   input  wire logic                      WR_MODE,
   input  wire logic                      SEVEN_TRACK,
   input  wire logic                      EVEN_PARITY,
   input  wire logic                      DENSITY_HIGH,
   // Tick at 32 times the character frequency.
   input  wire logic                      SKEW_TICK,
   // Write data from the controller.
   input  wire logic                      WR_STROBE,
   input  wire logic [TRACKS-2:0]         WR_DATA,
   input  wire logic [4*(TRACKS-1)-1:0]   DESKEW_SET,
   // Head drive.
   output logic                           HEAD_ON,
   output logic [TRACKS-1:0]              HEAD_DIR,
   // Read pulses from the rectified amplifiers.
   input  wire logic [TRACKS-1:0]         RD_PULSE,
   // Assembled read character.
   output logic [TRACKS-1:0]              RD_CHAR,
   output logic                           RD_VALID,
   output logic                           RD_PAR_ERR
);

   localparam int DW  = TRACKS - 1;
   localparam int REF = TRACKS - 1;

   // Refuse track counts that the seven-track mask and deskew nibbles
   // cannot serve, while the design is being elaborated.
   if (TRACKS < `SEVEN_DATA_BITS + 1 || TRACKS > 16) begin : g_bad_tracks
      $error("TRACKS must lie between 7 and 16");
   end

   // Parity over the data bits with the mode's selected sense.
   function automatic logic parity_bit(input logic [DW-1:0] d,
                                       input logic even);
      parity_bit = even ? ^d : ~(^d);
   endfunction

   // Tracks in use for the current track count.
   function automatic logic [TRACKS-1:0] used_mask(input logic seven);
      logic [TRACKS-1:0] m;
      m = '1;
      if (seven) begin
         m = '0;
         m[REF] = 1'b1;
         m[`SEVEN_DATA_BITS-1:0] = '1;
      end
      used_mask = m;
   endfunction

   logic                      even_sel;
   logic [TRACKS-1:0]         mask;
   logic [DW-1:0]             data_m;
   logic [TRACKS-1:0]         wr_char;
   logic [TRACKS-1:0]         start;
   logic [TRACKS-1:0]         fire;
   nrzi_codec_pkg::delay_t    delay_sel [TRACKS];
   logic [TRACKS-1:0]         head_r;
   logic                      head_on_r;

   // Even parity only in seven-track mode; nine-track is forced odd.
   assign even_sel = SEVEN_TRACK && EVEN_PARITY;
   // The mask is a net of its own, as a function result cannot be sliced.
   assign mask     = used_mask(SEVEN_TRACK);
   assign data_m   = WR_DATA & mask[DW-1:0];
   // Odd parity guarantees a one per character; even relies on the host.
   assign wr_char  = {parity_bit(data_m, even_sel), data_m};
   // A track starts its delay only when a one meets a write strobe.
   assign start = (WR_MODE && WR_STROBE) ? wr_char : '0;

   // Delay selection: reference fixed, others set when density is high.
   always_comb begin
      for (int i = 0; i < TRACKS; i++) begin
         delay_sel[i] = `REF_DELAY;
         if (i != REF && DENSITY_HIGH) begin
            delay_sel[i] = {1'b0, DESKEW_SET[4*i +: 4]};
         end
      end
   end

   // One delay channel per track.
   for (genvar g = 0; g < TRACKS; g++) begin : g_trk
      write_track_delay u_dly (
         .clk   (CLK),
         .rst   (RST),
         .tick  (SKEW_TICK),
         .start (start[g]),
         .delay (delay_sel[g]),
         .fire  (fire[g])
      );
   end

   // Head direction flip-flops: toggle per one, erased outside write mode.
   always_ff @(posedge CLK) begin
      if (RST || !WR_MODE) begin
         head_r <= {TRACKS{`ERASE_DIR}};
      end else begin
         head_r <= head_r ^ fire;
      end
   end

   // Head current flows whenever write mode is held.
   always_ff @(posedge CLK) begin
      if (RST) begin
         head_on_r <= 1'b0;
      end else begin
         head_on_r <= WR_MODE;
      end
   end

   assign HEAD_DIR = head_r;
   assign HEAD_ON  = head_on_r;

   // Read side.
   nrzi_codec_pkg::rd_state_e state_r;
   logic [TRACKS-1:0]         gather_r;
   logic [4:0]                win_r;
   logic [TRACKS-1:0]         char_r;
   logic                      valid_r;
   logic                      perr_r;
   logic                      any_pulse;
   logic                      win_end;

   // Any in-use track's pulse clocks the character; masked tracks are ignored.
   assign any_pulse = |(RD_PULSE & used_mask(SEVEN_TRACK));
   assign win_end   = SKEW_TICK && (win_r == `READ_WIN_TICKS - 5'h01);

   // Capture window sequence.
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r <= nrzi_codec_pkg::RD_IDLE;
      end else begin
         unique case (state_r)
            nrzi_codec_pkg::RD_IDLE: begin
               if (any_pulse) begin
                  state_r <= nrzi_codec_pkg::RD_GATHER;
               end
            end
            nrzi_codec_pkg::RD_GATHER: begin
               if (win_end) begin
                  state_r <= nrzi_codec_pkg::RD_EMIT;
               end
            end
            nrzi_codec_pkg::RD_EMIT: begin
               state_r <= nrzi_codec_pkg::RD_IDLE;
            end
            default: begin
               state_r <= nrzi_codec_pkg::RD_IDLE;
            end
         endcase
      end
   end

   // Window length counter, half a character in ticks.
   always_ff @(posedge CLK) begin
      if (RST || state_r != nrzi_codec_pkg::RD_GATHER) begin
         win_r <= 5'h00;
      end else if (SKEW_TICK) begin
         win_r <= win_r + 5'h01;
      end
   end

   // Deskew register: a pulse marks a one, silence leaves a zero.
   always_ff @(posedge CLK) begin
      if (RST || state_r == nrzi_codec_pkg::RD_EMIT) begin
         gather_r <= '0;
      end else if (state_r != nrzi_codec_pkg::RD_EMIT) begin
         gather_r <= gather_r | (RD_PULSE & used_mask(SEVEN_TRACK));
      end
   end

   // Output character, strobe and parity check.
   always_ff @(posedge CLK) begin
      if (RST) begin
         char_r  <= '0;
         valid_r <= 1'b0;
         perr_r  <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         if (state_r == nrzi_codec_pkg::RD_EMIT) begin
            char_r  <= gather_r;
            valid_r <= 1'b1;
            // Odd sense wants a set reduction, even sense a clear one.
            perr_r  <= (^gather_r) == even_sel;
         end
      end
   end

   assign RD_CHAR    = char_r;
   assign RD_VALID   = valid_r;
   assign RD_PAR_ERR = perr_r;

   // Checks.
   sequence s_fire_any;
      WR_MODE && (fire != '0);
   endsequence

   sequence s_toggle;
      head_r == ($past(head_r) ^ $past(fire));
   endsequence

   a_head_toggle: assert property (@(posedge CLK) disable iff (RST)
      s_fire_any ##1 WR_MODE |-> s_toggle)
      else $error("head did not toggle on fire");

   a_head_hold: assert property (@(posedge CLK) disable iff (RST)
      WR_MODE && fire == '0 ##1 WR_MODE |-> $stable(head_r))
      else $error("head changed without a one");

   a_gap_erase: assert property (@(posedge CLK) disable iff (RST)
      !WR_MODE |=> head_r == '0 && !HEAD_ON)
      else $error("gap not in erased direction");

   a_ref_fixed: assert property (@(posedge CLK) disable iff (RST)
      delay_sel[REF] == 5'h08)
      else $error("reference delay not eight");

   a_low_density: assert property (@(posedge CLK) disable iff (RST)
      !DENSITY_HIGH |-> delay_sel[0] == 5'h08)
      else $error("low density deskew not fixed");

   a_nine_odd: assert property (@(posedge CLK) disable iff (RST)
      !SEVEN_TRACK |-> ^wr_char)
      else $error("nine-track parity not odd");

   a_win_open: assert property (@(posedge CLK) disable iff (RST)
      state_r == nrzi_codec_pkg::RD_IDLE && any_pulse
      |=> state_r == nrzi_codec_pkg::RD_GATHER)
      else $error("window did not open on pulse");

   a_emit_clear: assert property (@(posedge CLK) disable iff (RST)
      state_r == nrzi_codec_pkg::RD_EMIT
      |=> RD_VALID && gather_r == '0 && RD_CHAR == $past(gather_r))
      else $error("character not emitted and cleared");

   a_one_kept: assert property (@(posedge CLK) disable iff (RST)
      state_r == nrzi_codec_pkg::RD_GATHER && RD_PULSE[0]
      |=> gather_r[0] || state_r == nrzi_codec_pkg::RD_EMIT)
      else $error("read pulse lost");

endmodule

`default_nettype wire

// ===== common/nrzi_codec_defines.svh
// Purpose: Timing counts and fixed values for the multitrack NRZI codec.
// Assumes: Delay ticks arrive at 32 times the character frequency.
// Notes:   Definitions only; included by bare name.
`ifndef NRZI_CODEC_DEFINES_SVH
`define NRZI_CODEC_DEFINES_SVH

// Delay ticks in one character period.
`define TICKS_PER_CHAR   6'h20
// Fixed write delay of the reference track, a quarter character.
`define REF_DELAY        5'h08
// Read capture window length in ticks, half a character period.
`define READ_WIN_TICKS   5'h10
// Head current direction that defines erased tape.
`define ERASE_DIR        1'b0
// Data tracks used in seven-track operation.
`define SEVEN_DATA_BITS  6

`endif

// ===== common/nrzi_codec_pkg.sv
// Purpose: Types shared by the multitrack NRZI codec.
// Assumes: Nothing beyond the defines header.
// Notes:   The read capture sequence uses one-hot codes.
package nrzi_codec_pkg;

   // Read capture window states.
   typedef enum logic [2:0] {
      RD_IDLE   = 3'b001,
      RD_GATHER = 3'b010,
      RD_EMIT   = 3'b100
   } rd_state_e;

   // Five-bit delay count in ticks.
   typedef logic [4:0] delay_t;

endpackage

// ===== logic/write_track_delay.sv
// Purpose: One track's write delay: fires a pulse a set number of ticks
//          after a start.
// Assumes: Ticks are one-cycle pulses at 32 times the character rate.
// Notes:   A delay of zero fires on the cycle after the start.
`timescale 1ns/10ps
`default_nettype none

module write_track_delay (
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Timing and control.
   input  wire logic                  tick,
   input  wire logic                  start,
   input  wire nrzi_codec_pkg::delay_t delay,
   // Delayed event.
   output logic                       fire
);

   logic                   pending_r;
   nrzi_codec_pkg::delay_t cnt_r;

   // The pending delay ends once the tick count reaches the set delay.
   assign fire = pending_r && (cnt_r >= delay);

   // Pending flag: a start arms it, the fire ends it.
   always_ff @(posedge clk) begin
      if (rst) begin
         pending_r <= 1'b0;
      end else if (start) begin
         pending_r <= 1'b1;
      end else if (fire) begin
         pending_r <= 1'b0;
      end
   end

   // Tick counter, cleared by each start; counts ticks only while pending and holds at 31.
   always_ff @(posedge clk) begin
      if (rst || start) begin
         cnt_r <= 5'h00;
      end else if (pending_r && tick && cnt_r != 5'h1f) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

endmodule

`default_nettype wire

// ===== testbench/tape_head_model.sv
// Purpose: Tape head model: records flux reversals and plays them back.
// Assumes: Read after write; flux is recorded only while current is on.
// Notes:   A drop mask loses chosen tracks, as a tape dropout would.
`timescale 1ns/10ps
`default_nettype none

module tape_head_model #(
   parameter int TRACKS = 9
) (
   // Clock.
   input  wire logic              clk,
   // Head drive from the write side.
   input  wire logic              head_on,
   input  wire logic [TRACKS-1:0] head_dir,
   // Tracks lost on playback.
   input  wire logic [TRACKS-1:0] drop,
   // Rectified playback pulses.
   output logic      [TRACKS-1:0] rd_pulse
);
   logic [TRACKS-1:0] dir_r;
   logic              on_r;

   // Each reversal made with current on plays back as one pulse.
   always_ff @(posedge clk) begin
      dir_r    <= head_dir;
      on_r     <= head_on;
      rd_pulse <= (head_dir ^ dir_r) & {TRACKS{head_on & on_r}} & ~drop;
   end
endmodule
`default_nettype wire

// ===== testbench/test_nrzi_multitrack_codec_deskew.sv
// Purpose: Self-checking bench: writes characters, reads them back.
// Assumes: Ticks every four cycles, so a character is 128 cycles.
// Notes:   Track delays are measured in ticks counted from the strobe.
`timescale 1ns/10ps
`default_nettype none

module test_nrzi_multitrack_codec_deskew;
   logic        CLK = 1'b0, RST = 1'b1, WR_MODE = 1'b0, SEVEN_TRACK = 1'b0;
   logic        EVEN_PARITY = 1'b0, DENSITY_HIGH = 1'b1, SKEW_TICK = 1'b0;
   logic        WR_STROBE = 1'b0, HEAD_ON, RD_VALID, RD_PAR_ERR;
   logic [7:0]  WR_DATA = 8'h00;
   logic [31:0] DESKEW_SET = 32'hc9753210;
   logic [8:0]  HEAD_DIR, RD_PULSE, RD_CHAR, drop = 9'h000;
   logic [1:0]  ph = 2'h0;
   int          mismatches = 0, n_compared = 0, cycles = 0;

   nrzi_multitrack_codec_deskew #(.TRACKS(9)) u_dut (.CLK(CLK), .RST(RST),
      .WR_MODE(WR_MODE), .SEVEN_TRACK(SEVEN_TRACK),
      .EVEN_PARITY(EVEN_PARITY), .DENSITY_HIGH(DENSITY_HIGH),
      .SKEW_TICK(SKEW_TICK), .WR_STROBE(WR_STROBE), .WR_DATA(WR_DATA),
      .DESKEW_SET(DESKEW_SET), .HEAD_ON(HEAD_ON), .HEAD_DIR(HEAD_DIR),
      .RD_PULSE(RD_PULSE), .RD_CHAR(RD_CHAR), .RD_VALID(RD_VALID),
      .RD_PAR_ERR(RD_PAR_ERR));
   tape_head_model #(.TRACKS(9)) u_head (.clk(CLK), .head_on(HEAD_ON),
      .head_dir(HEAD_DIR), .drop(drop), .rd_pulse(RD_PULSE));

   // Clock, one tick in four cycles, and a hang limit.
   always #10 CLK = ~CLK;
   always @(negedge CLK) begin
      ph        <= ph + 2'h1;
      SKEW_TICK <= (ph == 2'h3);
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_sim();
      end
   end

   // Compares one value and reports a mismatch.
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Writes one character, times each track, then reads it back.
   task automatic do_char(input logic [7:0] data, input logic perr);
      logic [7:0] md;
      logic [8:0] bits, prev, d0;
      int         seen [9];
      int         ticks;
      md   = SEVEN_TRACK ? (data & 8'h3f) : data;
      bits = {~(^md) ^ (SEVEN_TRACK & EVEN_PARITY), md};
      for (int i = 0; i < 9; i++) seen[i] = 511;
      @(posedge CLK iff SKEW_TICK === 1'b1);
      @(negedge CLK);
      WR_DATA   = data;
      WR_STROBE = 1'b1;
      d0        = HEAD_DIR;
      prev      = HEAD_DIR;
      ticks     = 0;
      repeat (56) begin
         @(posedge CLK);
         if (SKEW_TICK === 1'b1) ticks++;
         @(negedge CLK);
         WR_STROBE = 1'b0;
         for (int i = 0; i < 9; i++)
            if (HEAD_DIR[i] !== prev[i] && seen[i] == 511) seen[i] = ticks;
         prev = HEAD_DIR;
      end
      for (int i = 0; i < 9; i++)
         check(9'(seen[i]), !bits[i] ? 9'h1ff : 9'((i == 8 || !DENSITY_HIGH)
            ? 8 : DESKEW_SET[4*i+:4]));
      check(HEAD_DIR, d0 ^ bits);
      repeat (200) begin
         @(negedge CLK);
         if (RD_VALID === 1'b1) break;
      end
      check({8'h00, RD_VALID}, 9'h001);
      check(RD_CHAR, bits & ~drop);
      check({8'h00, RD_PAR_ERR}, {8'h00, perr});
      @(negedge CLK);
      check({8'h00, RD_VALID}, 9'h000);
   endtask

   // Checks that heads rest in the erased direction with current off.
   task automatic check_gap();
      check(HEAD_DIR, 9'h000);
      check({8'h00, HEAD_ON}, 9'h000);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("compared=%0d mismatches=%0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence: reset, gap, write and read in each mode.
   initial begin
      repeat (3) @(posedge CLK);
      @(negedge CLK);
      RST = 1'b0;
      check_gap();
      check({RD_CHAR | {7'h00, RD_VALID, RD_PAR_ERR}}, 9'h000);
      WR_DATA   = 8'hff;
      WR_STROBE = 1'b1;
      @(negedge CLK);
      WR_STROBE = 1'b0;
      repeat (60) @(negedge CLK);
      check_gap();
      WR_MODE = 1'b1;
      repeat (2) @(negedge CLK);
      check({8'h00, HEAD_ON}, 9'h001);
      do_char(8'h01, 1'b0);
      do_char(8'hff, 1'b0);
      do_char(8'h00, 1'b0);
      do_char(8'ha5, 1'b0);
      EVEN_PARITY = 1'b1;
      do_char(8'h03, 1'b0);
      DENSITY_HIGH = 1'b0;
      do_char(8'h5a, 1'b0);
      SEVEN_TRACK = 1'b1;
      do_char(8'hd5, 1'b0);
      EVEN_PARITY = 1'b0;
      do_char(8'h2a, 1'b0);
      SEVEN_TRACK  = 1'b0;
      DENSITY_HIGH = 1'b1;
      drop         = 9'h100;
      do_char(8'h03, 1'b1);
      WR_MODE = 1'b0;
      repeat (2) @(negedge CLK);
      check_gap();
      end_sim();
   end
endmodule
`default_nettype wire
